/* File: core/supervision_pkg.sv */
// Purpose: Shared constants and types for the supervision timer and the
//          system-reset generator.
// Assumes: Single 40 MHz clock, all delays counted in whole milliseconds.
// Notes:   Code tables are doubling series, decoded in the main module.

package supervision_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and millisecond tick
  localparam int CLK_HZ          = 40000000;  // mclk rate
  localparam int MS_PER_S        = 1000;
  localparam int MS_TICK_CYCLES  = CLK_HZ / MS_PER_S;  // 40000 cycles per ms
  localparam int DIV_WIDTH       = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond counter widths and limits
  localparam int MS_WIDTH        = 21;       // Holds 1638400 ms
  localparam int PERIOD_WIDTH    = 15;       // Holds 32256 ms
  localparam logic [PERIOD_WIDTH-1:0] PERIOD_MIN_MS = 15'h0001;  // 0.001 s
  localparam logic [PERIOD_WIDTH-1:0] PERIOD_MAX_MS = 15'h7E00;  // 32.256 s

  ////////////////////////////////////////////////////////////////////////////
  // Initial wait codes: 0 ms, then 100 ms doubling up to 1638 s
  localparam int INIT_CODE_WIDTH = 4;
  localparam logic [MS_WIDTH-1:0] INIT_WAIT_BASE_MS = 21'h000064;  // 100 ms

  ////////////////////////////////////////////////////////////////////////////
  // System-reset delay codes: 0 ms, then 1 ms doubling up to 32.8 s
  localparam int RST_CODE_WIDTH  = 5;
  localparam logic [RST_CODE_WIDTH-1:0] RST_CODE_MAX = 5'h10;  // 17 codes
  localparam logic [MS_WIDTH-1:0] RST_DELAY_BASE_MS = 21'h000001;  // 1 ms

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_START   = 2'b01,
    WD_RUN     = 2'b10,
    WD_EXPIRED = 2'b11
  } wd_state_type;

  typedef enum logic [2:0] {
    RS_HOLD      = 3'b000,
    RS_ON_DELAY  = 3'b001,
    RS_PULSE     = 3'b010,
    RS_RUN       = 3'b011,
    RS_OFF_DELAY = 3'b100,
    RS_TRACK     = 3'b101,
    RS_WD_HOLD   = 3'b110
  } rs_state_type;

endpackage

/* File: core/ms_countdown.sv */
// Purpose: Millisecond down-counter, loaded with a count and decremented
//          on each millisecond tick until it reaches zero.
// Assumes: tick is a one-cycle enable from the shared divider.
// Notes:   done is high whenever the count stands at zero.

`timescale 1ns/10ps
`default_nettype none

module ms_countdown #(
  parameter int WIDTH = 21
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // Status
  output logic                  done
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_state_type;

  cnt_state_type state_reg;
  cnt_state_type state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Load wins over a tick in the same cycle
  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.count = load_value;
    end else if (tick && (state_reg.count != '0)) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done = (state_reg.count == '0);

endmodule // ms_countdown

`default_nettype wire

/* File: core/supervision_reset.sv */
// Purpose: Supervision timer with kick input, expiry output and a
//          system-reset generator gated by rail power-good.
// Assumes: Config and rail status are steady levels on mclk; kick_cmd is
//          a one-cycle strobe from the I2C command decoder.
// Notes:   Delays resolve to whole ms; first tick may come up to 1 ms early.

`timescale 1ns/10ps
`default_nettype none

module supervision_reset #(
  parameter int MS_TICK_CYCLES = supervision_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Kick sources
  input  wire logic       timer_kick_input,
  input  wire logic       kick_active_high,
  input  wire logic       kick_pin_enable,
  input  wire logic       kick_cmd,
  // Supervision timer configuration
  input  wire logic       timer_enable,
  input  wire logic       timer_coupled,
  input  wire logic [3:0] initial_wait_code,
  input  wire logic [14:0] timeout_ms,
  input  wire logic       expiry_to_reset,
  input  wire logic       expiry_pin_enable,
  // System-reset configuration
  input  wire logic [4:0] reset_delay_code,
  input  wire logic       reset_pulse_mode,
  input  wire logic [14:0] pulse_width_ms,
  input  wire logic       tracking_release,
  // Rail status
  input  wire logic       rails_pg_on,
  input  wire logic       rails_pg_off,
  // Outputs
  output logic            timer_expiry_output,
  output logic            system_reset_out,
  output logic            timer_running,
  output logic            timer_expired
);

  typedef struct packed {
    supervision_pkg::wd_state_type wd_state;
    supervision_pkg::rs_state_type rs_state;
    logic [supervision_pkg::DIV_WIDTH-1:0] div;
    logic [2:0] kick_sync;
    logic       sys_reset;
    logic       expiry;
  } top_state_type;

  top_state_type state_reg;
  top_state_type state_next;

  logic                                 ms_tick;
  logic                                 kick_edge;
  logic                                 kick_level;
  logic                                 kick_event;
  logic                                 wd_allowed;
  logic                                 wd_load;
  logic [supervision_pkg::MS_WIDTH-1:0] wd_value;
  logic                                 wd_done;
  logic                                 rs_load;
  logic [supervision_pkg::MS_WIDTH-1:0] rs_value;
  logic                                 rs_done;
  logic [supervision_pkg::MS_WIDTH-1:0] init_ms;
  logic [supervision_pkg::MS_WIDTH-1:0] delay_ms;
  logic [supervision_pkg::MS_WIDTH-1:0] period_ms;
  logic [supervision_pkg::MS_WIDTH-1:0] width_ms;

  localparam logic [supervision_pkg::DIV_WIDTH-1:0] DIV_LAST =
    supervision_pkg::DIV_WIDTH'(MS_TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Clamp a programmed period into 1 ms .. 32.256 s
  function automatic logic [supervision_pkg::MS_WIDTH-1:0] clamp_period(
    input logic [supervision_pkg::PERIOD_WIDTH-1:0] raw
  );
    logic [supervision_pkg::PERIOD_WIDTH-1:0] v;
    v = raw;
    if (raw < supervision_pkg::PERIOD_MIN_MS) begin
      v = supervision_pkg::PERIOD_MIN_MS;
    end else if (raw > supervision_pkg::PERIOD_MAX_MS) begin
      v = supervision_pkg::PERIOD_MAX_MS;
    end
    return {6'h00, v};
  endfunction

  // Doubling code tables; code zero means no wait at all
  always_comb begin
    init_ms = '0;
    if (initial_wait_code != 4'h0) begin
      init_ms = supervision_pkg::INIT_WAIT_BASE_MS <<
                (initial_wait_code - 4'h1);
    end
    delay_ms = '0;
    if (reset_delay_code > supervision_pkg::RST_CODE_MAX) begin
      delay_ms = supervision_pkg::RST_DELAY_BASE_MS <<
                 (supervision_pkg::RST_CODE_MAX - 5'h01);
    end else if (reset_delay_code != 5'h00) begin
      delay_ms = supervision_pkg::RST_DELAY_BASE_MS <<
                 (reset_delay_code - 5'h01);
    end
    period_ms = clamp_period(timeout_ms);
    width_ms  = clamp_period(pulse_width_ms);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Kick detection: sync stage 0 is read only by stage 1
  assign kick_edge  = state_reg.kick_sync[2] ^ state_reg.kick_sync[1];
  assign kick_level = state_reg.kick_sync[1] ~^ kick_active_high;
  // Pin is optional; the command alone also restarts timing
  assign kick_event = (kick_pin_enable && kick_edge) || kick_cmd;
  assign ms_tick    = (state_reg.div == DIV_LAST);

  // Coupled timer only supervises while the processor is out of reset
  assign wd_allowed = timer_enable &&
    (!timer_coupled || (state_reg.rs_state == supervision_pkg::RS_RUN));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for divider, timer and reset generator
  always_comb begin
    state_next = state_reg;
    wd_load    = 1'b0;
    wd_value   = period_ms;
    rs_load    = 1'b0;
    rs_value   = delay_ms;

    // Free-running millisecond divider
    state_next.div = ms_tick ? '0 : state_reg.div + 1'b1;
    state_next.kick_sync = {state_reg.kick_sync[1:0], timer_kick_input};

    // Supervision timer
    case (state_reg.wd_state)
      supervision_pkg::WD_IDLE: begin
        if (wd_allowed) begin
          wd_load = 1'b1;
          if (init_ms == '0) begin
            state_next.wd_state = supervision_pkg::WD_RUN;
          end else begin
            wd_value = init_ms;
            state_next.wd_state = supervision_pkg::WD_START;
          end
        end
      end
      supervision_pkg::WD_START: begin
        if (!wd_allowed) begin
          state_next.wd_state = supervision_pkg::WD_IDLE;
        end else if (kick_event) begin
          wd_load = 1'b1;
          state_next.wd_state = supervision_pkg::WD_RUN;
        end else if (wd_done) begin
          // Wait over; the first full timeout begins now, unless a kick above began it sooner
          wd_load = 1'b1;
          state_next.wd_state = supervision_pkg::WD_RUN;
        end
      end
      supervision_pkg::WD_RUN: begin
        if (!wd_allowed) begin
          state_next.wd_state = supervision_pkg::WD_IDLE;
        end else if (kick_event) begin
          wd_load = 1'b1;
        end else if (wd_done) begin
          state_next.wd_state = supervision_pkg::WD_EXPIRED;
        end
      end
      supervision_pkg::WD_EXPIRED: begin
        // Stays stopped; only a kick or loss of permission leaves
        if (!wd_allowed) begin
          state_next.wd_state = supervision_pkg::WD_IDLE;
        end else if (kick_event) begin
          wd_load = 1'b1;
          state_next.wd_state = supervision_pkg::WD_RUN;
        end
      end
      default: begin
        state_next.wd_state = supervision_pkg::WD_IDLE;
      end
    endcase

    // Expiry pin is distinct from reset and optional
    state_next.expiry = expiry_pin_enable && !expiry_to_reset &&
      (state_next.wd_state == supervision_pkg::WD_EXPIRED);

    // System-reset generator
    case (state_reg.rs_state)
      supervision_pkg::RS_HOLD: begin
        if (rails_pg_on) begin
          rs_load = 1'b1;
          state_next.rs_state = supervision_pkg::RS_ON_DELAY;
        end
      end
      supervision_pkg::RS_ON_DELAY: begin
        if (!rails_pg_on) begin
          state_next.rs_state = supervision_pkg::RS_HOLD;
        end else if (rs_done && reset_pulse_mode) begin
          rs_load  = 1'b1;
          rs_value = width_ms;
          state_next.rs_state = supervision_pkg::RS_PULSE;
        end else if (rs_done) begin
          state_next.rs_state = supervision_pkg::RS_RUN;
        end
      end
      supervision_pkg::RS_PULSE: begin
        if (rs_done) begin
          state_next.rs_state = supervision_pkg::RS_RUN;
        end
      end
      supervision_pkg::RS_RUN: begin
        if (rails_pg_off && reset_pulse_mode) begin
          state_next.rs_state = supervision_pkg::RS_HOLD;
        end else if (rails_pg_off) begin
          rs_load = 1'b1;
          state_next.rs_state = supervision_pkg::RS_OFF_DELAY;
        end else if (expiry_to_reset && wd_allowed &&
                     (state_reg.wd_state != supervision_pkg::WD_EXPIRED) &&
                     (state_next.wd_state ==
                      supervision_pkg::WD_EXPIRED)) begin
          rs_load = !tracking_release;
          state_next.rs_state = tracking_release ?
            supervision_pkg::RS_TRACK : supervision_pkg::RS_WD_HOLD;
        end
      end
      supervision_pkg::RS_OFF_DELAY: begin
        if (rs_done) begin
          state_next.rs_state = supervision_pkg::RS_HOLD;
        end
      end
      supervision_pkg::RS_TRACK: begin
        // Release timing starts once the tracked input goes active
        if (kick_level) begin
          rs_load = 1'b1;
          state_next.rs_state = supervision_pkg::RS_WD_HOLD;
        end
      end
      supervision_pkg::RS_WD_HOLD: begin
        if (rs_done) begin
          state_next.rs_state = supervision_pkg::RS_RUN;
        end
      end
      default: begin
        state_next.rs_state = supervision_pkg::RS_HOLD;
      end
    endcase

    // Level mode holds reset outside RUN and RS_OFF_DELAY; pulse mode only while pulsing or in a watchdog hold
    case (state_next.rs_state)
      supervision_pkg::RS_HOLD,
      supervision_pkg::RS_ON_DELAY: begin
        state_next.sys_reset = !reset_pulse_mode;
      end
      supervision_pkg::RS_PULSE,
      supervision_pkg::RS_TRACK,
      supervision_pkg::RS_WD_HOLD: begin
        state_next.sys_reset = 1'b1;
      end
      default: begin
        state_next.sys_reset = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset asserted and timer idle after device reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.sys_reset <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two counters share the tick: one per independent timing path
  ms_countdown #(
    .WIDTH      (supervision_pkg::MS_WIDTH)
  ) u_wd_count (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .tick       (ms_tick),
    .load       (wd_load),
    .load_value (wd_value),
    .done       (wd_done)
  );

  ms_countdown #(
    .WIDTH      (supervision_pkg::MS_WIDTH)
  ) u_rs_count (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .tick       (ms_tick),
    .load       (rs_load),
    .load_value (rs_value),
    .done       (rs_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset and expiry pin straight from flops; timer status decoded from wd_state
  assign timer_expiry_output = state_reg.expiry;
  assign system_reset_out    = state_reg.sys_reset;
  assign timer_running =
    (state_reg.wd_state == supervision_pkg::WD_START) ||
    (state_reg.wd_state == supervision_pkg::WD_RUN);
  assign timer_expired =
    (state_reg.wd_state == supervision_pkg::WD_EXPIRED);

endmodule // supervision_reset

`default_nettype wire

/* File: testbench/supervision_chk.sv */
// Purpose: Port-level assertions for the supervision timer block.
// Assumes: MS_TICK_CYCLES of 2 or more; config steady around events.
// Notes:   Repeat counts below are sized for the small simulation tick.
`timescale 1ns/10ps
`default_nettype none
module supervision_chk #(
  parameter int MS_TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Watched inputs
  input wire logic        timer_kick_input,
  input wire logic        kick_cmd,
  input wire logic        timer_enable,
  input wire logic        timer_coupled,
  input wire logic        expiry_to_reset,
  input wire logic        expiry_pin_enable,
  input wire logic [4:0]  reset_delay_code,
  input wire logic        reset_pulse_mode,
  input wire logic [14:0] pulse_width_ms,
  input wire logic        rails_pg_on,
  input wire logic        rails_pg_off,
  // Watched outputs
  input wire logic        timer_expiry_output,
  input wire logic        system_reset_out,
  input wire logic        timer_expired
);
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] quiet_reg;
  logic       pin_reg;
  logic       low_seen_reg;
  int         hi_reg;
  // Pin quiet time; pulse runs are only checked once a low was seen in pulse mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg    <= 3'h0;
      pin_reg      <= 1'b0;
      low_seen_reg <= 1'b0;
      hi_reg       <= 0;
    end else begin
      pin_reg      <= timer_kick_input;
      quiet_reg    <= (timer_kick_input != pin_reg) ? 3'h0 :
                      (quiet_reg == 3'h7) ? 3'h7 : quiet_reg + 3'h1;
      low_seen_reg <= reset_pulse_mode & (low_seen_reg | ~system_reset_out);
      hi_reg       <= (system_reset_out && reset_pulse_mode) ? hi_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_kick_restart;
    timer_expired && kick_cmd |=> !timer_expired;
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("expired timer ignored kick command");
  property p_stay_stopped;
    timer_expired && !kick_cmd && timer_enable && !timer_coupled &&
      quiet_reg > 3'h3 |=> timer_expired;
  endproperty
  a_stay_stopped: assert property (p_stay_stopped)
    else $error("expired timer restarted without kick");
  property p_expiry_pin;
    $rose(timer_expired) && !expiry_to_reset && expiry_pin_enable
      |-> timer_expiry_output;
  endproperty
  a_expiry_pin: assert property (p_expiry_pin)
    else $error("expiry pin missing at expiry");
  property p_pin_cause;
    timer_expiry_output |-> timer_expired && !expiry_to_reset;
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("expiry pin without expiry");
  property p_wd_reset;
    $rose(timer_expired) && expiry_to_reset && !reset_pulse_mode &&
      !$past(system_reset_out) && !$past(rails_pg_off) |-> system_reset_out;
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("expiry did not assert reset");
  property p_reset_hold;
    $rose(system_reset_out) && reset_delay_code == 5'h04 && !reset_pulse_mode
      |-> system_reset_out [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("reset held too briefly");
  property p_hold_until_good;
    system_reset_out && !rails_pg_on && !reset_pulse_mode |=> system_reset_out;
  endproperty
  a_hold_until_good: assert property (p_hold_until_good)
    else $error("reset released before power good");
  property p_off_delay;
    $rose(rails_pg_off) && !reset_pulse_mode && !system_reset_out &&
      reset_delay_code == 5'h04 |-> (!system_reset_out) [*8];
  endproperty
  a_off_delay: assert property (p_off_delay)
    else $error("reassert came before delay");
  property p_pulse_width;
    $fell(system_reset_out) && reset_pulse_mode && !timer_enable &&
      low_seen_reg |-> hi_reg >= (int'(pulse_width_ms) - 1) * MS_TICK_CYCLES
      && hi_reg <= int'(pulse_width_ms) * MS_TICK_CYCLES + 2;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse width wrong");
  property p_no_pulse;
    reset_pulse_mode && !rails_pg_on && !system_reset_out && !timer_enable
      |=> !system_reset_out;
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("pulse without power good");
  c_release: cover property ($fell(system_reset_out));
  c_expiry: cover property ($rose(timer_expired));
  c_kick: cover property (timer_expired && kick_cmd);
endmodule // supervision_chk
bind supervision_reset supervision_chk #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk_u (.mclk, .rst_n, .timer_kick_input, .kick_cmd, .timer_enable,
  .timer_coupled, .expiry_to_reset, .expiry_pin_enable, .reset_delay_code,
  .reset_pulse_mode, .pulse_width_ms, .rails_pg_on, .rails_pg_off,
  .timer_expiry_output, .system_reset_out, .timer_expired);
`default_nettype wire

/* File: testbench/host_kick_model.sv */
// Purpose: Host processor driving the kick pin, prompt or slow.
// Assumes: Bench requests are levels set at the falling edge.
// Notes:   A held level wins over toggles, for tracking release.
`timescale 1ns/10ps
`default_nettype none
module host_kick_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Bench requests
  input  wire logic        toggle_req,
  input  wire logic        hold_en,
  input  wire logic        hold_level,
  input  wire logic [15:0] kick_period,
  // Kick pin
  output logic             timer_kick_input
);
  logic [15:0] gap_reg;
  // Pin moves just after the edge; zero period means a silent host
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_kick_input <= 1'b0;
      gap_reg          <= 16'h0000;
    end else if (hold_en) begin
      timer_kick_input <= hold_level;
    end else if (toggle_req ||
                 (kick_period != 16'h0000 && gap_reg >= kick_period)) begin
      timer_kick_input <= ~timer_kick_input;
      gap_reg          <= 16'h0000;
    end else begin
      gap_reg          <= gap_reg + 16'h0001;
    end
  end
endmodule // host_kick_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the supervision timer and reset.
// Assumes: One ms is T cycles; inputs change at the falling edge.
// Notes:   Codes above 15 skipped, they would outlast the run budget.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int T = 2;
  logic mclk = 1'b0;
  logic rst_n, kick_active_high, kick_pin_enable, kick_cmd, timer_enable;
  logic timer_coupled, expiry_to_reset, expiry_pin_enable, reset_pulse_mode;
  logic tracking_release, rails_pg_on, rails_pg_off, seen_exp;
  logic toggle_req, hold_en, hold_level;
  logic [3:0] initial_wait_code;
  logic [4:0] reset_delay_code;
  logic [14:0] timeout_ms, pulse_width_ms;
  logic [15:0] kick_period;
  wire logic timer_kick_input, timer_expiry_output, system_reset_out;
  wire logic timer_running, timer_expired;
  int failures, comparisons, n, d;
  ////////////////////////////////////////////////////////////////////////////
  supervision_reset #(.MS_TICK_CYCLES(T)) dut_u (.mclk, .rst_n,
    .timer_kick_input, .kick_active_high, .kick_pin_enable, .kick_cmd,
    .timer_enable, .timer_coupled, .initial_wait_code, .timeout_ms,
    .expiry_to_reset, .expiry_pin_enable, .reset_delay_code,
    .reset_pulse_mode, .pulse_width_ms, .tracking_release, .rails_pg_on,
    .rails_pg_off, .timer_expiry_output, .system_reset_out, .timer_running,
    .timer_expired);
  host_kick_model host_u (.mclk, .rst_n, .toggle_req, .hold_en,
    .hold_level, .kick_period, .timer_kick_input);
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  task automatic check(input logic seen, input logic expv, input string m);
    comparisons++;
    if (seen !== expv) begin
      failures++;
      $display("BAD at %0t ns: %s", $time, m);
    end
  endtask
  // Edges until an output settles at the wanted level, bounded
  task automatic wait_for(input logic sel, input logic want, output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
    end while (((sel ? timer_expired : system_reset_out) !== want) &&
               c < 70000);
  endtask
  function automatic int ms_of(input int code, input int base);
    return (code == 0) ? 0 : base << (code - 1);
  endfunction
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Run needs about 75k cycles; a hang is cut off past that
  initial begin
    #2500000;
    failures++;
    $display("BAD at %0t ns: run timed out", $time);
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {kick_cmd, timer_enable, timer_coupled, expiry_to_reset} = 4'h0;
    {kick_active_high, kick_pin_enable, expiry_pin_enable} = 3'h7;
    {reset_pulse_mode, tracking_release, rails_pg_on, rails_pg_off} = 4'h0;
    {toggle_req, hold_en, hold_level, seen_exp} = 4'h0;
    {initial_wait_code, reset_delay_code} = 9'h000;
    {timeout_ms, pulse_width_ms} = {15'h0001, 15'h0001};
    kick_period = 16'h0000;
    {failures, comparisons} = {32'h0, 32'h0};
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    // Release delay per code; later codes return to hold by a reset
    for (int c = 0; c < 16; c++) begin
      @(negedge mclk);
      reset_delay_code = 5'(c);
      d = ms_of(c, 1);
      repeat (3) @(negedge mclk);
      check(system_reset_out, 1'b1, "released early");
      rails_pg_on = 1'b1;
      wait_for(1'b0, 1'b0, n);
      check(n inside {[(d-1)*T:d*T+3]}, 1'b1, "on delay");
      @(negedge mclk);
      rails_pg_on = 1'b0;
      if (c < 9) begin
        rails_pg_off = 1'b1;
        wait_for(1'b0, 1'b1, n);
        check(n inside {[(d-1)*T:d*T+3]}, 1'b1, "off delay");
        @(negedge mclk);
        rails_pg_off = 1'b0;
      end else begin
        rst_n = 1'b0;
        @(negedge mclk);
        rst_n = 1'b1;
        check(system_reset_out, 1'b1, "reset level");
      end
    end
    $display("test reset delays done");
    // One pulse after 2 ms, at the narrowest and a wider width
    reset_pulse_mode = 1'b1;
    reset_delay_code = 5'h02;
    for (int w = 1; w < 7; w += 5) begin
      pulse_width_ms = 15'(w);
      repeat (3) @(negedge mclk);
      check(system_reset_out, 1'b0, "pulse idle");
      rails_pg_on = 1'b1;
      wait_for(1'b0, 1'b1, n);
      check(n inside {[T:2*T+3]}, 1'b1, "pulse delay");
      wait_for(1'b0, 1'b0, n);
      check(n inside {[(w-1)*T:w*T+2]}, 1'b1, "pulse width");
      repeat (12) @(negedge mclk);
      check(system_reset_out, 1'b0, "second pulse");
      {rails_pg_on, rails_pg_off} = 2'h1;
      repeat (12) @(negedge mclk);
      check(system_reset_out, 1'b0, "pulse mode off");
      rails_pg_off = 1'b0;
    end
    $display("test pulse done");
    // Initial wait plus timeout, then stopped until kicked
    reset_pulse_mode = 1'b0;
    for (int c = 0; c < 6; c++) begin
      initial_wait_code = 4'(c);
      timeout_ms = 15'(c + 3);
      expiry_pin_enable = (c != 5);
      kick_pin_enable = (c != 1);
      timer_enable = 1'b1;
      d = ms_of(c, 100) + c + 3;
      wait_for(1'b1, 1'b1, n);
      check(n inside {[(d-2)*T:d*T+4]}, 1'b1, "expiry time");
      check(timer_expiry_output, c != 5, "expiry pin");
      repeat (12) @(negedge mclk);
      check(timer_expired, 1'b1, "left stop alone");
      toggle_req = c[0];
      kick_cmd = !c[0];
      @(negedge mclk);
      {toggle_req, kick_cmd} = 2'h0;
      repeat (5) @(negedge mclk);
      check(timer_expired, c == 1, "kick");
      check(timer_expiry_output, c == 1, "pin after kick");
      timer_enable = 1'b0;
      repeat (2) @(negedge mclk);
    end
    // A host kicking every 2.5 ms holds off a 5 ms timeout
    {initial_wait_code, timeout_ms} = {4'h0, 15'h0005};
    kick_period = 16'(2 * T);
    timer_enable = 1'b1;
    repeat (200) begin
      @(posedge mclk);
      #1;
      seen_exp = seen_exp | timer_expired;
    end
    check(seen_exp, 1'b0, "expired while kicked");
    @(negedge mclk);
    kick_period = 16'h0000;
    wait_for(1'b1, 1'b1, n);
    check(n <= 5*T+6, 1'b1, "expiry after kicks stop");
    @(negedge mclk);
    timer_enable = 1'b0;
    $display("test timer done");
    // Coupled timer drives the reset; plain, then tracking each polarity
    {expiry_to_reset, timer_coupled, hold_en, rails_pg_on} = 4'hF;
    {reset_delay_code, timeout_ms} = {5'h03, 15'h0004};
    wait_for(1'b0, 1'b0, n);
    @(negedge mclk);
    timer_enable = 1'b1;
    for (int p = 0; p < 3; p++) begin
      tracking_release = (p != 0);
      kick_active_high = (p != 2);
      hold_level = (p == 2);
      wait_for(1'b0, 1'b1, n);
      check(n < 40, 1'b1, "no reset on expiry");
      check(timer_expiry_output, 1'b0, "pin in reset mode");
      repeat (2) @(negedge mclk);
      check(timer_running, 1'b0, "coupled timer ran");
      if (p != 0) begin
        repeat (30) @(negedge mclk);
        check(system_reset_out, 1'b1, "released early");
        hold_level = (p == 1);
      end
      wait_for(1'b0, 1'b0, n);
      check(n inside {[3*T-3:4*T+6]}, 1'b1, "hold length");
      @(negedge mclk);
    end
    $display("test watchdog reset done");
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
